// ### rtl/srfu_unit.sv
`timescale 1ns/10ps
`include "srfu_cfg.svh"
module srfu_unit (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [5:0] rot_func_i,
  input wire srfu_pkg::srfu_ops_t ops_i,
  output logic [31:0] result_o,
  output logic [5:0] pos_latch_o,
  output logic [5:0] size_latch_o,
  output srfu_pkg::srfu_status_t status_o
);
  logic [5:0] pos_reg;
  logic [5:0] pos_next;
  logic [5:0] size_reg;
  logic [5:0] size_next;
  logic [63:0] rot_src;
  logic [5:0] rot_cnt;
  logic [31:0] rot_out;
  logic [31:0] result;
  logic [1:0] ffo_upper;
  logic [31:0] m;
  logic [31:0] r;
  logic [31:0] zlit;
  logic [31:0] olit;

  // field mask of a given size; 32 or more keeps the whole word
  function automatic logic [31:0] fmask(input logic [5:0] n);
    logic [32:0] one;
    one = 33'h1 << n;
    fmask = n[5] ? 32'hffff_ffff : one[31:0] - 32'h1;
  endfunction

  // logical shifts; counts past 31 empty the word
  function automatic logic [31:0] shl(input logic [31:0] x,
                                      input logic [5:0] n);
    shl = n[5] ? 32'h0 : x << n[4:0];
  endfunction
  function automatic logic [31:0] shr(input logic [31:0] x,
                                     input logic [5:0] n);
    shr = n[5] ? 32'h0 : x >> n[4:0];
  endfunction

  // rotate a word left
  function automatic logic [31:0] rol(input logic [31:0] x,
                                      input logic [4:0] n);
    logic [63:0] d;
    d = {x, x} << n;
    rol = d[63:32];
  endfunction

  // index of the highest set bit of a byte
  function automatic logic [2:0] msb_idx(input logic [7:0] b);
    msb_idx = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (b[i]) begin
        msb_idx = 3'(i);
      end
    end
  endfunction

  assign m = ops_i.first;
  assign r = ops_i.second;
  assign zlit = {23'h0, ops_i.literal};
  assign olit = {23'h7f_ffff, ops_i.literal};

  // zero-byte indicators pick the leftmost nonzero byte
  always_comb begin
    if (!ops_i.zero_ind[3]) begin
      ffo_upper = 2'b11;
    end else if (!ops_i.zero_ind[2]) begin
      ffo_upper = 2'b10;
    end else if (!ops_i.zero_ind[1]) begin
      ffo_upper = 2'b01;
    end else begin
      ffo_upper = 2'b00;
    end
  end

  // source and count for the shared 64-bit rotator
  // left rotates are right rotates by the 64 complement
  always_comb begin
    rot_src = {m, r};
    rot_cnt = pos_reg;
    case (rot_func_i)
      `SRFU_F_XZ_MM, `SRFU_F_RR_MM_P, `SRFU_F_XZ_PTX,
      `SRFU_F_XZ_VPN: begin
        rot_src = {m, m};
      end
      `SRFU_F_XZ_RR, `SRFU_F_RR_RR_P: begin
        rot_src = {r, r};
      end
      `SRFU_F_RR_MR_S: begin
        rot_cnt = size_reg;
      end
      `SRFU_F_RL_RM_4: begin
        rot_src = {r, m};
        rot_cnt = `SRFU_N_RL4;
      end
      `SRFU_F_RR_MR_4: begin
        rot_cnt = `SRFU_N_4;
      end
      `SRFU_F_RR_RR_SZ: begin
        rot_src = {r, r};
        rot_cnt = {ops_i.size_code + 3'h1, 3'h0};
      end
      `SRFU_F_RR_MR_9: begin
        rot_cnt = `SRFU_N_9;
      end
      `SRFU_F_RL_MM_S: begin
        rot_src = {m, m};
        rot_cnt = 6'h0 - size_reg;
      end
      `SRFU_F_RR_RR_S: begin
        rot_src = {r, r};
        rot_cnt = size_reg;
      end
      `SRFU_F_RL_RM_PS: begin
        rot_src = {r, m};
        rot_cnt = 6'h0 - (pos_reg + size_reg);
      end
      `SRFU_F_RL_MM_P: begin
        rot_src = {m, m};
        rot_cnt = 6'h0 - pos_reg;
      end
      `SRFU_F_RL_RR_P: begin
        rot_src = {r, r};
        rot_cnt = 6'h0 - pos_reg;
      end
      `SRFU_F_RL_RM_P: begin
        rot_src = {r, m};
        rot_cnt = 6'h0 - pos_reg;
      end
      `SRFU_F_RR_MR_PS: begin
        rot_cnt = pos_reg + size_reg;
      end
      `SRFU_F_RR_MM_PS: begin
        rot_src = {m, m};
        rot_cnt = pos_reg + size_reg;
      end
      `SRFU_F_RR_RR_PS: begin
        rot_src = {r, r};
        rot_cnt = pos_reg + size_reg;
      end
      `SRFU_F_FFO: begin
        rot_src = {m, m};
        rot_cnt = {1'b0, ffo_upper, 3'h0};
      end
      default: rot_src = {m, r};
    endcase
  end

  srfu_rotator u_rot (
    .data_i(rot_src),
    .count_i(rot_cnt),
    .low_o(rot_out)
  );

  // result bus, combinational within the microcycle
  always_comb begin
    case (rot_func_i)
      `SRFU_F_XZ_MR, `SRFU_F_XZ_MM, `SRFU_F_XZ_RR: begin
        result = rot_out & fmask(size_reg);
      end
      `SRFU_F_XZ_PTX, `SRFU_F_XZ_VPN: begin
        result = (m >> `SRFU_VA_POS) & fmask(`SRFU_VA_SIZE);
      end
      `SRFU_F_RR_MR_P, `SRFU_F_RR_MM_P, `SRFU_F_RR_RR_P,
      `SRFU_F_RR_MR_S, `SRFU_F_RL_RM_4, `SRFU_F_RR_MR_4,
      `SRFU_F_RR_RR_SZ, `SRFU_F_RR_MR_9, `SRFU_F_RL_MM_S,
      `SRFU_F_RR_RR_S, `SRFU_F_RL_RM_PS, `SRFU_F_RL_MM_P,
      `SRFU_F_RL_RR_P, `SRFU_F_RL_RM_P, `SRFU_F_RR_MR_PS,
      `SRFU_F_RR_MM_PS, `SRFU_F_RR_RR_PS, `SRFU_F_FFO: begin
        result = rot_out;
      end
      `SRFU_F_ASR_MP: result = shr(m, pos_reg);
      `SRFU_F_ASR_MNP: result = shr(m, 6'h0 - pos_reg);
      `SRFU_F_ASR_M3: result = shr(m, `SRFU_N_3);
      `SRFU_F_ASL_R7: result = shl(r, `SRFU_N_7);
      `SRFU_F_ASL_RP: result = shl(r, pos_reg);
      `SRFU_F_ASL_MP: result = shl(m, pos_reg);
      `SRFU_F_ASL_RSZ: result = shl(r, {4'h0, ops_i.size_code});
      `SRFU_F_NIB: result = {28'h0, m[3:0]};
      `SRFU_F_EXP: result = {24'h0, m[14:7]};
      // hidden bit, high and low fraction, low byte from second
      `SRFU_F_FPF: begin
        result = {1'b1, m[6:0], m[31:16], r[7:0]};
      end
      // caller has the fraction high in first, exponent low in second
      `SRFU_F_FLOAT_PACK_MERGE: begin
        result = {m[24:9], r[8], r[7:0], m[31:25]};
      end
      `SRFU_F_FLOAT_LITERAL_EXPAND: begin
        result = {16'h0, 1'b0, 5'h10, m[5:3], m[2:0], 4'h0};
      end
      `SRFU_F_CLR1: result = {m[31:8], 8'h0};
      `SRFU_F_CLR2: result = {m[31:16], 16'h0};
      `SRFU_F_CLR3: result = {m[31:24], 24'h0};
      `SRFU_F_ZERO: result = 32'h0;
      `SRFU_F_ONES: result = 32'hffff_ffff;
      `SRFU_F_SIZE: begin
        result = 32'h1 << ops_i.size_code;
      end
      `SRFU_F_BCD_BYTE_SWAP: begin
        result = {m[7:0], m[15:8], m[23:16], m[31:24]};
      end
      // digits OR'ed with the constant the caller placed on second
      `SRFU_F_PACKED_TO_NUMERIC: begin
        result = {4'h0, m[3:0], 4'h0, m[7:4],
                  4'h0, m[11:8], 4'h0, m[15:12]} | r;
      end
      `SRFU_F_NUMERIC_TO_PACKED: begin
        result = {m[3:0], m[11:8], m[19:16], m[27:24],
                  r[3:0], r[11:8], r[19:16], r[27:24]};
      end
      `SRFU_F_RD_POS, `SRFU_F_RDP_LDS: begin
        result = {26'h0, pos_reg};
      end
      `SRFU_F_RD_SIZE, `SRFU_F_RDS_LDP: begin
        result = {26'h0, size_reg};
      end
      `SRFU_F_ZERO_LITERAL_LATCH_ROTATE: result = rol(zlit, pos_reg[4:0]);
      `SRFU_F_OLIT0, `SRFU_F_LD_POS, `SRFU_F_LD_SIZE,
      `SRFU_F_LD_PUP: begin
        result = olit;
      end
      `SRFU_F_OLIT24: result = rol(olit, 5'd24);
      `SRFU_F_OLIT16: result = rol(olit, 5'd16);
      `SRFU_F_OLIT8: result = rol(olit, 5'd8);
      default: begin
        // 30..37 rotate the zero-extended literal by 0,28,24..4
        if ({rot_func_i[5:3], 3'h0} == `SRFU_F_ZLIT0) begin
          result = rol(zlit, 5'(6'd32 - {1'b0, rot_func_i[2:0], 2'h0}));
        end else begin
          result = 32'h0;
        end
      end
    endcase
  end

  assign result_o = result;

  // position latch next value
  always_comb begin
    case (rot_func_i)
      `SRFU_F_LD_POS: pos_next = ops_i.literal[5:0];
      `SRFU_F_RDS_LDP: pos_next = ops_i.write_back[5:0];
      `SRFU_F_LD_PUP: begin
        pos_next = {pos_reg[5], ops_i.write_back[1:0],
                    pos_reg[2:0]};
      end
      // bit 5 cleared: the found index is always below 32
      `SRFU_F_FFO: begin
        pos_next = {1'b0, ffo_upper, msb_idx(rot_out[7:0])};
      end
      default: pos_next = pos_reg;
    endcase
  end

  // size latch next value
  always_comb begin
    case (rot_func_i)
      `SRFU_F_LD_SIZE: size_next = ops_i.literal[5:0];
      `SRFU_F_RDP_LDS: size_next = ops_i.write_back[5:0];
      default: size_next = size_reg;
    endcase
  end

  // latches update at the edge that closes the microcycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pos_reg <= `SRFU_RESET_LATCH;
    end else begin
      pos_reg <= pos_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      size_reg <= `SRFU_RESET_LATCH;
    end else begin
      size_reg <= size_next;
    end
  end

  assign pos_latch_o = pos_reg;
  assign size_latch_o = size_reg;

  // branch conditions, all combinational from latches and result
  always_comb begin
    status_o.result_zero = (result == 32'h0);
    status_o.pos_zero = (pos_reg == 6'h0);
    status_o.size_zero = (size_reg == 6'h0);
    status_o.pos_high = pos_reg[5];
  end

  nib_get_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_NIB |-> result_o == {28'h0, ops_i.first[3:0]})
    else $error("nibble get result wrong");
  exp_get_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_EXP |-> result_o[31:8] == 24'h0 &&
    result_o[7:0] == ops_i.first[14:7])
    else $error("exponent get result wrong");
  clear_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_CLR2 |->
    result_o == {ops_i.first[31:16], 16'h0})
    else $error("clear two bytes wrong");
  size_const_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_SIZE && ops_i.size_code == 2'b11 |->
    result_o == 32'h8)
    else $error("size constant wrong");
  pos_lit_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_LD_POS |->
    result_o == {23'h7f_ffff, ops_i.literal} ##1
    pos_latch_o == $past(ops_i.literal[5:0]) && $stable(size_latch_o))
    else $error("position literal load wrong");
  ffo_upper_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_FFO && ops_i.zero_ind == 4'b1101 |=>
    pos_latch_o[4:3] == 2'b01)
    else $error("leftmost byte position wrong");
  ffo_index_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_FFO && result_o[7:6] == 2'b01 |=>
    pos_latch_o[2:0] == 3'b110)
    else $error("highest bit index wrong");
  pos_upper_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_LD_PUP |=>
    pos_latch_o[4:3] == $past(ops_i.write_back[1:0]) &&
    pos_latch_o[5] == $past(pos_latch_o[5]) &&
    pos_latch_o[2:0] == $past(pos_latch_o[2:0]))
    else $error("position upper bits load wrong");
  latch_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_RD_SIZE |->
    result_o == {26'h0, size_latch_o} ##1
    $stable(pos_latch_o) && $stable(size_latch_o))
    else $error("latch read disturbed latches");
  swap_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rot_func_i == `SRFU_F_RDP_LDS |->
    result_o[31:6] == 26'h0 ##1
    size_latch_o == $past(ops_i.write_back[5:0]) && $stable(pos_latch_o))
    else $error("swap load wrong");
endmodule

// ### rtl/srfu_cfg.svh
`ifndef SRFU_CFG_SVH
`define SRFU_CFG_SVH
// widths
`define SRFU_W 32
`define SRFU_LW 6
// rotator function field codes
`define SRFU_F_XZ_MR 6'h00
`define SRFU_F_XZ_MM 6'h01
`define SRFU_F_XZ_RR 6'h02
`define SRFU_F_ASR_MP 6'h03
`define SRFU_F_RR_MR_P 6'h04
`define SRFU_F_RR_MM_P 6'h05
`define SRFU_F_RR_RR_P 6'h06
`define SRFU_F_RR_MR_S 6'h07
`define SRFU_F_RL_RM_4 6'h08
`define SRFU_F_RR_MR_4 6'h09
`define SRFU_F_RR_RR_SZ 6'h0a
`define SRFU_F_RR_MR_9 6'h0b
`define SRFU_F_XZ_PTX 6'h0c
`define SRFU_F_XZ_VPN 6'h0d
`define SRFU_F_NIB 6'h0e
`define SRFU_F_EXP 6'h0f
`define SRFU_F_FPF 6'h10
`define SRFU_F_FLOAT_PACK_MERGE 6'h11
`define SRFU_F_CLR1 6'h12
`define SRFU_F_CLR2 6'h13
`define SRFU_F_CLR3 6'h14
`define SRFU_F_ASL_R7 6'h15
`define SRFU_F_ZERO 6'h16
`define SRFU_F_ASL_RSZ 6'h17
`define SRFU_F_BCD_BYTE_SWAP 6'h18
`define SRFU_F_PACKED_TO_NUMERIC 6'h19
`define SRFU_F_RL_MM_S 6'h1a
`define SRFU_F_RR_RR_S 6'h1b
`define SRFU_F_SIZE 6'h1c
`define SRFU_F_ASR_M3 6'h1d
`define SRFU_F_FLOAT_LITERAL_EXPAND 6'h1e
`define SRFU_F_NUMERIC_TO_PACKED 6'h1f
`define SRFU_F_RL_RM_PS 6'h20
`define SRFU_F_RL_MM_P 6'h21
`define SRFU_F_RL_RR_P 6'h22
`define SRFU_F_RL_RM_P 6'h23
`define SRFU_F_RR_MR_PS 6'h24
`define SRFU_F_RR_MM_PS 6'h25
`define SRFU_F_RR_RR_PS 6'h26
`define SRFU_F_FFO 6'h27
`define SRFU_F_ASL_RP 6'h28
`define SRFU_F_ASL_MP 6'h29
`define SRFU_F_ASR_MNP 6'h2a
`define SRFU_F_ZERO_LITERAL_LATCH_ROTATE 6'h2b
`define SRFU_F_RD_POS 6'h2c
`define SRFU_F_RDP_LDS 6'h2d
`define SRFU_F_RD_SIZE 6'h2e
`define SRFU_F_RDS_LDP 6'h2f
`define SRFU_F_ZLIT0 6'h30
`define SRFU_F_OLIT0 6'h38
`define SRFU_F_ONES 6'h39
`define SRFU_F_OLIT24 6'h3a
`define SRFU_F_LD_POS 6'h3b
`define SRFU_F_OLIT16 6'h3c
`define SRFU_F_LD_SIZE 6'h3d
`define SRFU_F_OLIT8 6'h3e
`define SRFU_F_LD_PUP 6'h3f
// fixed counts and field positions
`define SRFU_N_RL4 6'd60
`define SRFU_N_4 6'd4
`define SRFU_N_9 6'd9
`define SRFU_N_7 6'd7
`define SRFU_N_3 6'd3
`define SRFU_VA_POS 6'd9
`define SRFU_VA_SIZE 6'd21
`define SRFU_RESET_LATCH 6'h00
`endif

// ### rtl/srfu_pkg.sv
package srfu_pkg;
  // operand buses and side inputs of one microcycle
  typedef struct packed {
    logic [31:0] first;
    logic [31:0] second;
    logic [31:0] write_back;
    logic [8:0] literal;
    logic [1:0] size_code;
    logic [3:0] zero_ind;
  } srfu_ops_t;
  // microbranch conditions
  typedef struct packed {
    logic result_zero;
    logic pos_zero;
    logic size_zero;
    logic pos_high;
  } srfu_status_t;
endpackage

// ### rtl/srfu_rotator.sv
`timescale 1ns/10ps
// 64-bit rotate right, low word returned
module srfu_rotator (
  input wire logic [63:0] data_i,
  input wire logic [5:0] count_i,
  output logic [31:0] low_o
);
  logic [127:0] twice;
  assign twice = {data_i, data_i};
  assign low_o = twice[count_i +: 32];
endmodule

// ### testbench/srfu_seq_model.sv
`timescale 1ns/10ps
// stands in for the microsequencer and the arithmetic unit, which feed
// the operand buses, literal, size code and zero-byte indicators
module srfu_seq_model (
  input wire logic [31:0] first_i,
  input wire logic [31:0] second_i,
  input wire logic [31:0] wb_i,
  input wire logic [8:0] lit_i,
  input wire logic [1:0] size_i,
  output srfu_pkg::srfu_ops_t ops_o
);
  // buses pass straight through; the caller places fraction, exponent
  // and conversion constants on them before asking for the function
  always_comb begin
    ops_o.first = first_i;
    ops_o.second = second_i;
    ops_o.write_back = wb_i;
    ops_o.literal = lit_i;
    ops_o.size_code = size_i;
    // the arithmetic unit always passes the first operand here, so the
    // indicators describe that bus, as the find-first function needs
    for (int k = 0; k < 4; k++) begin
      ops_o.zero_ind[k] = (first_i[8*k+:8] == 8'h00);
    end
  end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/10ps
`include "srfu_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module testbench;
  localparam logic [31:0] M = 32'h87654321;
  localparam logic [31:0] R = 32'h0fedcba9;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] fn = 6'h16;
  logic [31:0] m = 32'h0;
  logic [31:0] r = 32'h0;
  logic [31:0] w = 32'h0;
  logic [8:0] lit = 9'h0;
  logic [1:0] sz = 2'h0;
  srfu_pkg::srfu_ops_t ops;
  srfu_pkg::srfu_status_t st;
  logic [31:0] res;
  logic [5:0] pl;
  logic [5:0] sl;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  // 100 MHz microcycle clock
  always #5 clk_i = ~clk_i;

  srfu_seq_model seq (.first_i(m), .second_i(r), .wb_i(w), .lit_i(lit),
    .size_i(sz), .ops_o(ops));
  srfu_unit DUT (.clk_i(clk_i), .reset_i(reset_i), .rot_func_i(fn),
    .ops_i(ops), .result_o(res), .pos_latch_o(pl), .size_latch_o(sl),
    .status_o(st));

  function automatic logic [31:0] rl(input logic [31:0] v, input int n);
    return (v << n) | (v >> (32 - n));
  endfunction

  // one microinstruction: driven at the edge, result looked at 1 ns later
  // while latch loads still wait for the closing edge
  task automatic op(input logic [5:0] f, input logic [31:0] mm, rr, ww,
    input logic [8:0] ll, input logic [1:0] ss = 2'h0);
    @(posedge clk_i);
    fn <= f;
    m <= mm;
    r <= rr;
    w <= ww;
    lit <= ll;
    sz <= ss;
    #1;
  endtask

  task automatic t_reset();
    `CHK(pl, 6'h00)
    `CHK(sl, 6'h00)
    `CHK(st.pos_zero, 1'b1)
    `CHK(st.size_zero, 1'b1)
  endtask

  // back-to-back loads and reads of both latches
  task automatic t_latch();
    op(`SRFU_F_LD_POS, M, R, 32'h0, 9'h1ab);
    `CHK(res, 32'hffffffab)
    `CHK(pl, 6'h00)
    op(`SRFU_F_RD_POS, M, R, 32'h0, 9'h0);
    `CHK(pl, 6'h2b)
    `CHK(res, 32'h0000002b)
    op(`SRFU_F_LD_SIZE, M, R, 32'h0, 9'h0c5);
    `CHK(res, 32'hfffffec5)
    op(`SRFU_F_RD_SIZE, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h00000005)
    `CHK(pl, 6'h2b)
    op(`SRFU_F_LD_PUP, M, R, 32'h00000002, 9'h0);
    op(`SRFU_F_RDP_LDS, M, R, 32'h0000fff8, 9'h0);
    `CHK(pl, 6'h33)
    `CHK(res, 32'h00000033)
    `CHK(st.pos_high, 1'b1)
    op(`SRFU_F_RDS_LDP, M, R, 32'h00000011, 9'h0);
    `CHK(sl, 6'h38)
    `CHK(res, 32'h00000038)
    op(`SRFU_F_ZERO_LITERAL_LATCH_ROTATE, M, R, 32'h0, 9'h1ff);
    `CHK(pl, 6'h11)
    `CHK(res, rl(32'h1ff, 17))
  endtask

  // every fixed-count literal code, zero- and one-extended
  task automatic t_lit();
    int zc[8] = '{0, 28, 24, 20, 16, 12, 8, 4};
    int oc[4] = '{0, 24, 16, 8};
    for (int i = 0; i < 8; i++) begin
      op(`SRFU_F_ZLIT0 + 6'(i), M, R, 32'h0, 9'h1a5);
      `CHK(res, rl(32'h1a5, zc[i]))
    end
    for (int i = 0; i < 4; i++) begin
      op(`SRFU_F_OLIT0 + 6'(2 * i), M, R, 32'h0, 9'h0a5);
      `CHK(res, rl(32'hfffffea5, oc[i]))
    end
  endtask

  // find-first-one across top, middle and bottom byte cases
  task automatic t_ffo();
    logic [31:0] fv[4] = '{32'h00120000, 32'h80000000, 32'h00000001,
      32'h00004000};
    logic [7:0] fb[4] = '{8'h12, 8'h80, 8'h01, 8'h40};
    logic [5:0] fp[4] = '{6'h14, 6'h1f, 6'h00, 6'h0e};
    for (int i = 0; i < 4; i++) begin
      op(`SRFU_F_FFO, fv[i], R, 32'h0, 9'h0);
      `CHK(res[7:0], fb[i])
      op(`SRFU_F_RD_POS, M, R, 32'h0, 9'h0);
      `CHK(pl, fp[i])
    end
  endtask

  // get, clear, constant and convert functions on fixed operands
  task automatic t_data();
    op(`SRFU_F_NIB, M, R, 32'h0, 9'h0);
    `CHK(res, M & 32'hf)
    op(`SRFU_F_EXP, M, R, 32'h0, 9'h0);
    `CHK(res, (M >> 7) & 32'hff)
    op(`SRFU_F_FPF, M, R, 32'h0, 9'h0);
    `CHK(res, 32'ha18765a9)
    op(`SRFU_F_FLOAT_PACK_MERGE, M, R, 32'h0, 9'h0);
    `CHK(res, 32'hb2a1d4c3)
    op(`SRFU_F_CLR1, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h87654300)
    op(`SRFU_F_CLR2, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h87650000)
    op(`SRFU_F_CLR3, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h87000000)
    op(`SRFU_F_ZERO, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h0)
    `CHK(st.result_zero, 1'b1)
    op(`SRFU_F_ONES, M, R, 32'h0, 9'h0);
    `CHK(res, 32'hffffffff)
    for (int i = 0; i < 4; i++) begin
      op(`SRFU_F_SIZE, M, R, 32'h0, 9'h0, 2'(i));
      `CHK(res, 32'h1 << i)
    end
    op(`SRFU_F_BCD_BYTE_SWAP, 32'h78563412, R, 32'h0, 9'h0);
    `CHK(res, 32'h12345678)
    op(`SRFU_F_PACKED_TO_NUMERIC, 32'h00001234, 32'h30303030, 32'h0, 9'h0);
    `CHK(res, 32'h34333231)
    op(`SRFU_F_NUMERIC_TO_PACKED, 32'h34333231, 32'h38373635, 32'h0, 9'h0);
    `CHK(res, 32'h12345678)
  endtask

  // rotates and extracts with counts taken from the latches, the size code and fixed values
  task automatic t_rot();
    op(`SRFU_F_LD_POS, M, R, 32'h0, 9'h008);
    op(`SRFU_F_LD_SIZE, M, R, 32'h0, 9'h00c);
    op(`SRFU_F_RR_MR_P, M, R, 32'h0, 9'h0);
    `CHK(res, {M[7:0], R[31:8]})
    op(`SRFU_F_XZ_MR, M, R, 32'h0, 9'h0);
    `CHK(res, {M[7:0], R[31:8]} & 32'hfff)
    op(`SRFU_F_RL_RM_4, M, R, 32'h0, 9'h0);
    `CHK(res, {M[27:0], R[31:28]})
    `CHK(st.size_zero, 1'b0)
    op(`SRFU_F_XZ_MM, M, R, 32'h0, 9'h0);
    `CHK(res, rl(M, 24) & 32'hfff)
    op(`SRFU_F_XZ_RR, M, R, 32'h0, 9'h0);
    `CHK(res, rl(R, 24) & 32'hfff)
    op(`SRFU_F_RR_MM_P, M, R, 32'h0, 9'h0);
    `CHK(res, rl(M, 24))
    op(`SRFU_F_RR_RR_P, M, R, 32'h0, 9'h0);
    `CHK(res, rl(R, 24))
    op(`SRFU_F_RR_MR_S, M, R, 32'h0, 9'h0);
    `CHK(res, {M[11:0], R[31:12]})
    op(`SRFU_F_RR_MR_4, M, R, 32'h0, 9'h0);
    `CHK(res, {M[3:0], R[31:4]})
    op(`SRFU_F_RR_MR_9, M, R, 32'h0, 9'h0);
    `CHK(res, {M[8:0], R[31:9]})
    op(`SRFU_F_RR_RR_SZ, M, R, 32'h0, 9'h0, 2'h1);
    `CHK(res, rl(R, 16))
    op(`SRFU_F_RR_RR_SZ, M, R, 32'h0, 9'h0, 2'h3);
    `CHK(res, R)
    op(`SRFU_F_RL_MM_S, M, R, 32'h0, 9'h0);
    `CHK(res, rl(M, 12))
    op(`SRFU_F_RR_RR_S, M, R, 32'h0, 9'h0);
    `CHK(res, rl(R, 20))
    op(`SRFU_F_RL_RM_PS, M, R, 32'h0, 9'h0);
    `CHK(res, {M[11:0], R[31:12]})
    op(`SRFU_F_RL_MM_P, M, R, 32'h0, 9'h0);
    `CHK(res, rl(M, 8))
    op(`SRFU_F_RL_RR_P, M, R, 32'h0, 9'h0);
    `CHK(res, rl(R, 8))
    op(`SRFU_F_RL_RM_P, M, R, 32'h0, 9'h0);
    `CHK(res, {M[23:0], R[31:24]})
    op(`SRFU_F_RR_MR_PS, M, R, 32'h0, 9'h0);
    `CHK(res, {M[19:0], R[31:20]})
    op(`SRFU_F_RR_MM_PS, M, R, 32'h0, 9'h0);
    `CHK(res, rl(M, 12))
    op(`SRFU_F_RR_RR_PS, M, R, 32'h0, 9'h0);
    `CHK(res, rl(R, 12))
  endtask

  // shifts, fixed extracts and literal expand; position still 8
  task automatic t_shift();
    op(`SRFU_F_ASR_MP, M, R, 32'h0, 9'h0);
    `CHK(res, M >> 8)
    op(`SRFU_F_ASR_MNP, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h0)
    op(`SRFU_F_ASR_M3, M, R, 32'h0, 9'h0);
    `CHK(res, M >> 3)
    op(`SRFU_F_ASL_R7, M, R, 32'h0, 9'h0);
    `CHK(res, R << 7)
    op(`SRFU_F_ASL_RP, M, R, 32'h0, 9'h0);
    `CHK(res, R << 8)
    op(`SRFU_F_ASL_MP, M, R, 32'h0, 9'h0);
    `CHK(res, M << 8)
    op(`SRFU_F_ASL_RSZ, M, R, 32'h0, 9'h0, 2'h2);
    `CHK(res, R << 2)
    op(`SRFU_F_XZ_PTX, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h0003b2a1)
    op(`SRFU_F_XZ_VPN, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h0003b2a1)
    op(`SRFU_F_FLOAT_LITERAL_EXPAND, M, R, 32'h0, 9'h0);
    `CHK(res, 32'h00004210)
  endtask

  task automatic end_sim();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // the whole run needs well under two hundred microcycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    t_reset();
    t_latch();
    t_lit();
    t_ffo();
    t_data();
    t_rot();
    t_shift();
    end_sim();
  end
endmodule
